// file: design/touch_irq_map.svh
`ifndef TOUCH_IRQ_MAP_SVH
`define TOUCH_IRQ_MAP_SVH
// register offsets
`define OFS_MAIN_CTL 8'h00
`define OFS_GEN_STAT 8'h02
`define OFS_SENSE_STAT 8'h03
`define OFS_NOISE_STAT 8'h0A
`define OFS_GEN_CFG 8'h20
`define OFS_SENSE_CFG 8'h22
`define OFS_SENSE_CFG2 8'h23
`define OFS_IRQ_EN 8'h27
`define OFS_REPEAT_EN 8'h28
`define OFS_SEC_CFG 8'h44
// reset values
`define RST_GEN_CFG 8'h20
`define RST_SENSE_CFG 8'hA4
`define RST_SENSE_CFG2 8'h07
`define RST_IRQ_EN 8'hFF
`define RST_REPEAT_EN 8'hFF
`define RST_SEC_CFG 8'h40
// field positions
`define BIT_INT 0
`define BIT_LF_DIS 4
`define BIT_SPIKE_DIS 5
`define BIT_REL_SEL 0
`define BIT_RF_DIS 2
`define BIT_ACAL_IEN 4
`define BIT_BLIM_IEN 5
`define BIT_RF_ONLY 7
`define BIT_GS_TOUCH 0
`define BIT_GS_PATTERN 2
`define BIT_GS_PWR 4
`define BIT_GS_ACAL 5
`define BIT_GS_BLIM 6
`define BIT_GS_RESET 7
// timing
`define CLK_NS 25
`define TICK_MS 35
`endif

// file: design/touch_irq_pkg.sv
package touch_irq_pkg;
    typedef logic [7:0] byte_t; // one register byte
    typedef logic [7:0][7:0] chan_bytes_t; // one byte per channel
    typedef enum {IDLE, PRESS, HELD, PWR_WAIT, PWR_DONE} press_state_e;
endpackage : touch_irq_pkg

// file: design/chan_evt_if.sv
`timescale 1ns/100ps
interface chan_evt_if;
    logic touched; // qualified touch level
    logic rep_en; // repeat rate enabled
    logic is_pwr; // channel is the active power button
    logic touch_evt; // pulse: new touch
    logic release_evt; // pulse: touch ended
    logic repeat_evt; // pulse: repeat period elapsed
    logic pwr_evt; // pulse: power hold time reached
    logic held; // level: press-and-hold reached
    modport ctl (output touched, rep_en, is_pwr,
        input touch_evt, release_evt, repeat_evt, pwr_evt, held);
    modport timer (input touched, rep_en, is_pwr,
        output touch_evt, release_evt, repeat_evt, pwr_evt, held);
endinterface : chan_evt_if

// file: design/press_timer.sv
`timescale 1ns/100ps
module press_timer (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // timebase and settings
    input wire logic tick,
    input wire logic [3:0] min_press_timer,
    input wire logic [3:0] repeat_rate,
    input wire logic [7:0] pwr_hold,
    // channel link
    chan_evt_if.timer link
);
    import touch_irq_pkg::*;

    press_state_e state_reg; // press tracking state
    logic [7:0] cnt_reg; // ticks in current phase
    logic prev_reg; // touch level one cycle ago
    logic rise; // touch begins
    logic fall; // touch ends

    assign rise = link.touched & ~prev_reg;
    assign fall = ~link.touched & prev_reg;

    // edge history
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            prev_reg <= 1'b0;
        else
            prev_reg <= link.touched;
    end

    // press phases; a release at any time returns to idle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= IDLE;
            cnt_reg <= 8'h00;
        end
        else
        begin
            case (state_reg)
                IDLE:
                begin
                    cnt_reg <= 8'h00;
                    if (rise)
                        state_reg <= link.is_pwr ? PWR_WAIT : PRESS;
                end
                PRESS:
                begin
                    if (!link.touched)
                        state_reg <= IDLE;
                    else if (tick && link.rep_en &&
                             cnt_reg == {4'h0, min_press_timer})
                    begin
                        state_reg <= HELD;
                        cnt_reg <= 8'h00;
                    end
                    else if (tick && cnt_reg != 8'hFF)
                        cnt_reg <= cnt_reg + 8'h01;
                end
                HELD:
                begin
                    if (!link.touched)
                        state_reg <= IDLE;
                    else if (tick)
                        cnt_reg <= (cnt_reg == {4'h0, repeat_rate}) ?
                            8'h00 : cnt_reg + 8'h01;
                end
                PWR_WAIT:
                begin
                    if (!link.touched)
                        state_reg <= IDLE;
                    else if (tick && cnt_reg == pwr_hold)
                        state_reg <= PWR_DONE;
                    else if (tick)
                        cnt_reg <= cnt_reg + 8'h01;
                end
                PWR_DONE:
                begin
                    // one power event per touch
                    if (!link.touched)
                        state_reg <= IDLE;
                end
                default:
                    state_reg <= IDLE;
            endcase
        end
    end

    // events: power button never reports a touch, and reports a release only if it became the key mid-press
    assign link.touch_evt = rise & ~link.is_pwr;
    assign link.release_evt = fall &
        (state_reg == PRESS || state_reg == HELD);
    // repeats stop at once if the channel loses repeat or becomes the key
    assign link.repeat_evt = (state_reg == HELD) & link.touched & tick &
        link.rep_en & ~link.is_pwr &
        (cnt_reg == {4'h0, repeat_rate});
    assign link.pwr_evt = (state_reg == PWR_WAIT) & link.touched & tick &
        (cnt_reg == pwr_hold);
    assign link.held = (state_reg == HELD);

    pwr_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        rise && link.is_pwr |-> !link.touch_evt ##1 state_reg == PWR_WAIT)
        else $error("power button reported an immediate touch");
    repeat_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        link.repeat_evt |-> link.rep_en && !link.is_pwr)
        else $error("repeat event without repeat enable");
endmodule : press_timer

// file: design/touch_noise_irq.sv
`timescale 1ns/100ps
`include "touch_irq_map.svh"
module touch_noise_irq #(
    parameter int TICK_CYCLES = `TICK_MS * 1000000 / `CLK_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port from the serial protocol engine
    input wire touch_irq_pkg::byte_t reg_addr,
    input wire touch_irq_pkg::byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output touch_irq_pkg::byte_t reg_rdata,
    // analog noise detectors, asynchronous
    input wire touch_irq_pkg::byte_t lf_noise_det,
    input wire touch_irq_pkg::byte_t rf_noise_det,
    // conversion results and thresholds
    input wire logic sample_strobe,
    input wire touch_irq_pkg::chan_bytes_t delta_cnt,
    input wire touch_irq_pkg::chan_bytes_t active_thr,
    input wire touch_irq_pkg::chan_bytes_t standby_thr,
    input wire touch_irq_pkg::byte_t noise_thr,
    input wire logic standby_state,
    // power button setup
    input wire logic pwr_en,
    input wire logic [2:0] pwr_sel,
    input wire touch_irq_pkg::byte_t pwr_hold,
    // other event sources
    input wire logic touch_pattern_match,
    input wire logic pattern_block,
    input wire logic analog_cal_fail_flag,
    input wire logic base_limit_flag,
    // results
    output touch_irq_pkg::byte_t sample_discard,
    output touch_irq_pkg::byte_t recal_exclude,
    output touch_irq_pkg::byte_t hold_status,
    output logic alert_n
);
    import touch_irq_pkg::*;

    generate
        if (TICK_CYCLES < 1)
        begin : bad_tick
            $error("TICK_CYCLES must be at least one");
        end
    endgenerate

    byte_t gen_cfg_reg; // general configuration
    byte_t sec_cfg_reg; // secondary configuration
    byte_t sense_cfg_reg; // repeat rate in low nibble
    byte_t sense_cfg2_reg; // minimum press timer in low nibble
    byte_t irq_en_reg; // per-channel interrupt enable
    byte_t repeat_en_reg; // per-channel repeat enable
    byte_t gen_stat_reg; // sticky general status
    byte_t sense_stat_reg; // sticky touch status
    byte_t noise_stat_reg; // sticky noise flags
    byte_t touched_reg; // qualified touch per channel
    byte_t lf_meta_reg; // first sync stage
    byte_t lf_sync_reg; // second sync stage
    byte_t rf_meta_reg;
    byte_t rf_sync_reg;
    logic int_reg; // interrupt bit
    logic rst_pend_reg; // reset event still to report
    logic [31:0] tick_cnt_reg; // timebase divider
    logic tick; // one-cycle timebase enable
    byte_t discard; // sample thrown away
    byte_t flag_set; // noise flag source
    byte_t spike; // noise spike class
    byte_t over_thr; // above touch threshold
    byte_t chan_irq; // channel interrupt request
    byte_t pwr_hit; // power hold reached
    logic int_clr; // host writes interrupt bit to zero
    logic any_evt;
    logic acal_irq;
    logic blim_irq;
    logic pwr_irq;

    chan_evt_if link [8] ();

    // strict greater-than decode used by touch and spike tests
    function automatic logic exceeds(input byte_t val, input byte_t lim);
        exceeds = (val > lim);
    endfunction : exceeds

    // noise detectors arrive from the analog side
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lf_meta_reg <= 8'h00;
            lf_sync_reg <= 8'h00;
            rf_meta_reg <= 8'h00;
            rf_sync_reg <= 8'h00;
        end
        else
        begin
            lf_meta_reg <= lf_noise_det;
            lf_sync_reg <= lf_meta_reg;
            rf_meta_reg <= rf_noise_det;
            rf_sync_reg <= rf_meta_reg;
        end
    end

    // shared timebase for press, repeat and power timers
    always_ff @(posedge clk)
    begin
        if (sys_rst || tick)
            tick_cnt_reg <= 32'h0;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
    assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

    // per-channel qualification and timers
    generate
        for (genvar c = 0; c < 8; c++)
        begin : chan
            byte_t thr;
            assign thr = standby_state ? standby_thr[c] : active_thr[c];
            assign discard[c] =
                (lf_sync_reg[c] & ~gen_cfg_reg[`BIT_LF_DIS]) |
                (rf_sync_reg[c] & ~sec_cfg_reg[`BIT_RF_DIS]);
            assign flag_set[c] = sec_cfg_reg[`BIT_RF_ONLY] ?
                rf_sync_reg[c] :
                (lf_sync_reg[c] | rf_sync_reg[c]);
            assign over_thr[c] = exceeds(delta_cnt[c], thr);
            assign spike[c] = exceeds(delta_cnt[c], noise_thr) &
                ~over_thr[c];
            assign link[c].touched = touched_reg[c];
            assign link[c].rep_en = repeat_en_reg[c];
            assign link[c].is_pwr = pwr_en && (pwr_sel == 3'(c));
            assign chan_irq[c] = irq_en_reg[c] & (link[c].touch_evt |
                link[c].repeat_evt | (link[c].release_evt &
                ~sec_cfg_reg[`BIT_REL_SEL]));
            assign pwr_hit[c] = link[c].pwr_evt;
            assign hold_status[c] = link[c].held;

            press_timer u_timer (
                .clk(clk),
                .sys_rst(sys_rst),
                .tick(tick),
                .min_press_timer(sense_cfg2_reg[3:0]),
                .repeat_rate(sense_cfg_reg[3:0]),
                .pwr_hold(pwr_hold),
                .link(link[c])
            );
        end
    endgenerate

    // touch decision only from kept samples; pattern events block touches
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            touched_reg <= 8'h00;
        else if (sample_strobe)
            touched_reg <= (touched_reg & discard) |
                (over_thr & ~discard & {8{~pattern_block}});
    end

    // per-sample side outputs for the recalibration engine
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sample_discard <= 8'h00;
            recal_exclude <= 8'h00;
        end
        else
        begin
            sample_discard <= sample_strobe ? discard : 8'h00;
            recal_exclude <= sample_strobe ? (discard | (spike &
                {8{gen_cfg_reg[`BIT_SPIKE_DIS]}})) : 8'h00;
        end
    end

    assign int_clr = reg_wr && reg_addr == `OFS_MAIN_CTL &&
        !reg_wdata[`BIT_INT];
    assign acal_irq = analog_cal_fail_flag &
        sec_cfg_reg[`BIT_ACAL_IEN];
    assign blim_irq = base_limit_flag & sec_cfg_reg[`BIT_BLIM_IEN];
    assign pwr_irq = |pwr_hit;
    assign any_evt = (|chan_irq) | pwr_irq | touch_pattern_match |
        acal_irq | blim_irq | rst_pend_reg;

    // reset is reported once, on the first cycle after release
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rst_pend_reg <= 1'b1;
        else
            rst_pend_reg <= 1'b0;
    end

    // interrupt bit and alert flop share one next value
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            int_reg <= 1'b0;
            alert_n <= 1'b1;
        end
        else if (any_evt)
        begin
            int_reg <= 1'b1;
            alert_n <= 1'b0;
        end
        else if (int_clr)
        begin
            int_reg <= 1'b0;
            alert_n <= 1'b1;
        end
    end

    // sticky status; set beats the host clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            gen_stat_reg <= 8'h00;
            sense_stat_reg <= 8'h00;
            noise_stat_reg <= 8'h00;
        end
        else
        begin
            gen_stat_reg <= (int_clr ? 8'h00 : gen_stat_reg) |
                ({7'h0, |touched_reg} << `BIT_GS_TOUCH) |
                ({7'h0, touch_pattern_match} << `BIT_GS_PATTERN) |
                ({7'h0, pwr_irq} << `BIT_GS_PWR) |
                ({7'h0, analog_cal_fail_flag} << `BIT_GS_ACAL) |
                ({7'h0, base_limit_flag} << `BIT_GS_BLIM) |
                ({7'h0, rst_pend_reg} << `BIT_GS_RESET);
            // a released key stays visible until the next clear
            sense_stat_reg <= (int_clr ? touched_reg : sense_stat_reg) |
                (touched_reg & ~{8{pwr_en}}) | pwr_hit;
            noise_stat_reg <= (int_clr ? 8'h00 : noise_stat_reg) |
                (sample_strobe ? flag_set : 8'h00);
        end
    end

    // host-writable configuration
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            gen_cfg_reg <= `RST_GEN_CFG;
            sec_cfg_reg <= `RST_SEC_CFG;
            sense_cfg_reg <= `RST_SENSE_CFG;
            sense_cfg2_reg <= `RST_SENSE_CFG2;
            irq_en_reg <= `RST_IRQ_EN;
            repeat_en_reg <= `RST_REPEAT_EN;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `OFS_GEN_CFG: gen_cfg_reg <= reg_wdata;
                `OFS_SEC_CFG: sec_cfg_reg <= reg_wdata;
                `OFS_SENSE_CFG: sense_cfg_reg <= reg_wdata;
                `OFS_SENSE_CFG2: sense_cfg2_reg <= reg_wdata;
                `OFS_IRQ_EN: irq_en_reg <= reg_wdata;
                `OFS_REPEAT_EN: repeat_en_reg <= reg_wdata;
                default: ; // read-only and unmapped writes are dropped
            endcase
        end
    end

    // read data; unmapped offsets read zero
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `OFS_MAIN_CTL: reg_rdata <= {7'h0, int_reg} << `BIT_INT;
                `OFS_GEN_STAT: reg_rdata <= gen_stat_reg;
                `OFS_SENSE_STAT: reg_rdata <= sense_stat_reg;
                `OFS_NOISE_STAT: reg_rdata <= noise_stat_reg;
                `OFS_GEN_CFG: reg_rdata <= gen_cfg_reg;
                `OFS_SEC_CFG: reg_rdata <= sec_cfg_reg;
                `OFS_SENSE_CFG: reg_rdata <= sense_cfg_reg;
                `OFS_SENSE_CFG2: reg_rdata <= sense_cfg2_reg;
                `OFS_IRQ_EN: reg_rdata <= irq_en_reg;
                `OFS_REPEAT_EN: reg_rdata <= repeat_en_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    lf_discard_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_strobe && lf_sync_reg[0] && !gen_cfg_reg[`BIT_LF_DIS]
        |=> sample_discard[0] && touched_reg[0] == $past(touched_reg[0]))
        else $error("low-frequency noisy sample was used");
    rf_discard_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_strobe && rf_sync_reg[0] && !sec_cfg_reg[`BIT_RF_DIS]
        |=> touched_reg[0] == $past(touched_reg[0]))
        else $error("rf noisy sample changed touch state");
    any_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_strobe && !sec_cfg_reg[`BIT_RF_ONLY] && lf_sync_reg[1]
        |=> noise_stat_reg[1])
        else $error("noise flag missed with any-noise select");
    rf_only_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_strobe && sec_cfg_reg[`BIT_RF_ONLY] && !rf_sync_reg[2] &&
        !noise_stat_reg[2] |=> !noise_stat_reg[2])
        else $error("noise flag set without rf noise");
    spike_skip_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_strobe && spike[3] && gen_cfg_reg[`BIT_SPIKE_DIS]
        |=> recal_exclude[3])
        else $error("noise spike kept for recalibration");
    int_alert_a: assert property (@(posedge clk) disable iff (sys_rst)
        any_evt |=> int_reg && !alert_n)
        else $error("event did not raise interrupt and alert");
    alert_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !alert_n && !int_clr |=> !alert_n)
        else $error("alert released without host clear");
    alert_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        alert_n == !int_reg)
        else $error("alert does not mirror interrupt bit");
    chan_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        !irq_en_reg[4] |-> !chan_irq[4])
        else $error("disabled channel requested interrupt");
    cal_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        acal_irq |-> sec_cfg_reg[`BIT_ACAL_IEN] ##1 int_reg)
        else $error("calibration failure interrupt misgated");
    reset_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |=> !alert_n && gen_stat_reg[`BIT_GS_RESET])
        else $error("reset event not reported");
    pwr_stat_a: assert property (@(posedge clk) disable iff (sys_rst)
        pwr_irq |=> gen_stat_reg[`BIT_GS_PWR] && int_reg)
        else $error("power hold not reported");
endmodule : touch_noise_irq

// file: bench/host_model.sv
`timescale 1ns/100ps
`include "touch_irq_map.svh"
module host_model (
    // clock
    input wire logic clk,
    // register port
    output touch_irq_pkg::byte_t reg_addr,
    output touch_irq_pkg::byte_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire touch_irq_pkg::byte_t reg_rdata
);
    import touch_irq_pkg::*;
    // idle bus at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one write; released lines show the inverse, not a stale value
    task automatic wr(input byte_t a, input byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    // one read; data sampled an edge after the strobe is taken
    task automatic rd(input byte_t a, output byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
    // status is polled twice so a late release is not missed
    task automatic rd_twice(input byte_t a, output byte_t d);
        rd(a, d);
        rd(a, d);
    endtask : rd_twice
    // writing zero to the main control drops the interrupt bit
    task automatic clr();
        wr(`OFS_MAIN_CTL, 8'h00);
    endtask : clr
endmodule : host_model

// file: bench/touch_noise_and_interrupt_logic_bench.sv
`timescale 1ns/100ps
`include "touch_irq_map.svh"
module touch_noise_and_interrupt_logic_bench;
    import touch_irq_pkg::*;
    // clock, reset, register port
    logic clk, sys_rst, reg_wr, reg_rd;
    byte_t reg_addr, reg_wdata, reg_rdata;
    // sensing inputs
    byte_t lf, rf, nthr, phold, disc, rexc, hold, r, ds, rx, v, ea;
    chan_bytes_t delta, athr, sthr;
    logic strobe, stby, pwr_en, pm, pblk, cal, blim, alert_n;
    logic [2:0] psel;
    // bookkeeping
    int err_count, n_checks, seed;
    touch_noise_irq #(.TICK_CYCLES(4)) u_touch_noise_irq (.clk(clk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .lf_noise_det(lf), .rf_noise_det(rf), .sample_strobe(strobe),
        .delta_cnt(delta), .active_thr(athr), .standby_thr(sthr),
        .noise_thr(nthr), .standby_state(stby), .pwr_en(pwr_en),
        .pwr_sel(psel), .pwr_hold(phold), .touch_pattern_match(pm),
        .pattern_block(pblk), .analog_cal_fail_flag(cal),
        .base_limit_flag(blim), .sample_discard(disc),
        .recal_exclude(rexc), .hold_status(hold), .alert_n(alert_n));
    host_model u_host_model (.clk(clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // expected touch and spike decisions
    function automatic logic is_touch(byte_t d, byte_t t);
        return d > t;
    endfunction : is_touch
    function automatic logic is_spike(byte_t d, byte_t t);
        return (d > nthr) && !(d > t);
    endfunction : is_spike
    // compare one byte result
    task automatic chk(input string n, input byte_t e, input byte_t g);
        n_checks++;
        if (g !== e)
        begin
            $display("FAIL %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    // wait n cycles, gathering the one-cycle pulses
    task automatic run(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            ds = ds | disc;
            rx = rx | rexc;
        end
    endtask : run
    // one conversion with a single channel non-zero
    task automatic pulse(input int c, input byte_t d);
        chan_bytes_t t;
        t = '0;
        t[c] = d;
        @(posedge clk);
        delta <= t;
        strobe <= 1'b1;
        @(posedge clk);
        strobe <= 1'b0;
        // the result pulses stand only from this edge to the next
        #1;
        ds = ds | disc;
        rx = rx | rexc;
    endtask : pulse
    // fire cal fail, base limit or pattern for one cycle
    task automatic fire(input int k);
        @(posedge clk);
        cal <= (k == 0);
        blim <= (k == 1);
        pm <= (k == 2);
        @(posedge clk);
        {cal, blim, pm} <= 3'h0;
        run(3);
    endtask : fire
    // verdict, reached from the sequence or the watchdog
    task automatic report_and_stop();
        if (err_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // hang guard, far beyond the sequence length
    initial
    begin
        #(25 * 5000);
        err_count++;
        report_and_stop();
    end
    // main sequence
    initial
    begin
        {sys_rst, lf, rf, strobe, delta, stby, pwr_en} = '1;
        {lf, rf, strobe, delta, stby, pwr_en, pm, pblk, cal, blim} = '0;
        {err_count, n_checks, ds, rx} = '0;
        seed = 87;
        athr = {8{8'h40}};
        sthr = {8{8'h80}};
        nthr = 8'h10;
        psel = 3'h1;
        phold = 8'h02;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        run(3);
        chk("alert", 8'h00, {7'h0, alert_n});
        u_host_model.rd_twice(`OFS_GEN_STAT, r);
        chk("reset flag", 8'h80, r & 8'h80);
        u_host_model.rd(`OFS_GEN_CFG, r);
        chk("gen cfg", `RST_GEN_CFG, r);
        u_host_model.rd(`OFS_SEC_CFG, r);
        chk("sec cfg", `RST_SEC_CFG, r);
        u_host_model.rd(8'h55, r);
        chk("unmapped", 8'h00, r);
        u_host_model.clr();
        run(2);
        chk("alert", 8'h01, {7'h0, alert_n});
        u_host_model.wr(`OFS_REPEAT_EN, 8'h00);
        // edge values, then random deltas on every channel
        for (int i = 0; i < 12; i++)
        begin
            v = (i == 0) ? 8'h40 : (i == 1) ? 8'h41 : (i == 2) ? 8'h10
                : byte_t'($random(seed));
            {ds, rx} = '0;
            pulse(i % 8, v);
            run(6);
            ea = {7'h0, ~is_touch(v, 8'h40)};
            chk("touch", ea, {7'h0, alert_n});
            if (!is_touch(v, 8'h40))
                chk("spike", {7'h0, is_spike(v, 8'h40)}, rx >> i % 8);
            // clear first so that only the release can pull alert low
            u_host_model.clr();
            pulse(i % 8, 8'h00);
            run(6);
            chk("release", ea, {7'h0, alert_n});
            u_host_model.clr();
        end
        u_host_model.wr(`OFS_IRQ_EN, 8'h00);
        pulse(3, 8'h80);
        run(6);
        chk("masked", 8'h01, {7'h0, alert_n});
        pulse(3, 8'h00);
        u_host_model.wr(`OFS_IRQ_EN, 8'hFF);
        @(posedge clk) stby <= 1'b1;
        rx = '0;
        pulse(5, 8'h60);
        run(6);
        chk("stby spike", 8'h20, (rx & 8'h20) | {7'h0, ~alert_n});
        // back to active thresholds so that blocked touches are real ones
        @(posedge clk) {stby, lf} <= {1'b0, 8'h01};
        run(3);
        ds = '0;
        pulse(0, 8'h80);
        run(6);
        chk("lf block", 8'h03, (ds & 8'h01) | {6'h0, alert_n, 1'b0});
        u_host_model.rd(`OFS_NOISE_STAT, r);
        chk("lf flag", 8'h01, r & 8'h01);
        u_host_model.clr();
        u_host_model.wr(`OFS_SEC_CFG, 8'hC0);
        @(posedge clk) rf <= 8'h02;
        run(3);
        pulse(1, 8'h80);
        run(6);
        chk("rf block", 8'h01, {7'h0, alert_n});
        u_host_model.rd(`OFS_NOISE_STAT, r);
        chk("rf only", 8'h02, r & 8'h03);
        @(posedge clk) {lf, rf} <= '0;
        // calibration failure and base limit, masked then enabled
        for (int k = 0; k < 2; k++)
        begin
            u_host_model.wr(`OFS_SEC_CFG, 8'h40);
            fire(k);
            chk("irq off", 8'h01, {7'h0, alert_n});
            u_host_model.wr(`OFS_SEC_CFG, 8'h40 | (8'h10 << k));
            fire(k);
            chk("irq on", 8'h00, {7'h0, alert_n});
            u_host_model.clr();
        end
        fire(2);
        chk("pattern", 8'h00, {7'h0, alert_n});
        u_host_model.clr();
        @(posedge clk) pwr_en <= 1'b1;
        pulse(1, 8'h80);
        run(6);
        chk("pwr early", 8'h01, {7'h0, alert_n});
        run(20);
        chk("pwr late", 8'h00, {7'h0, alert_n});
        u_host_model.rd(`OFS_GEN_STAT, r);
        chk("pwr flag", 8'h10, r & 8'h10);
        // press and hold on a repeat channel: press field 7 gives hold
        // after 8 ticks, repeat field 4 gives a repeat every 5 ticks
        u_host_model.wr(`OFS_REPEAT_EN, 8'h04);
        u_host_model.clr();
        pulse(2, 8'h80);
        run(2);
        chk("rep touch", 8'h00, {7'h0, alert_n});
        u_host_model.clr();
        run(40);
        chk("press hold", 8'h05, hold | {7'h0, alert_n});
        run(12);
        chk("repeat", 8'h04, hold | {7'h0, alert_n});
        u_host_model.clr();
        pulse(2, 8'h00);
        run(6);
        chk("held release", 8'h00, hold | {7'h0, alert_n});
        report_and_stop();
    end
endmodule : touch_noise_and_interrupt_logic_bench
